// ==== hw/hci_host.sv ====
/*
  Host end of the transceiver control port: issues one register read or write per command in
  parallel Motorola, parallel Intel or serial form, and makes the device reset pulse.
  Assumes commands come from logic on clk_sys_in; pins from the device are resynchronised.
*/
`timescale 1ns/1ps
`include "hci_defines.svh"
module hci_host
  import hci_pkg::*;
#(
  parameter int READY_CYC = `HCI_READY_MS * 1000000 / `HCI_CLK_NS
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Device pins
  hci_bus_if.host bus,
  // Mode straps
  input wire logic serial_mode_in,
  input wire logic intel_mode_in,
  // Command
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [`HCI_ADDR_W-1:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  output logic cmd_ready_out,
  // Answer
  output logic rsp_valid_out,
  output logic [7:0] rsp_rdata_out,
  output logic irq_out
);
  // A reset pulse strictly longer than the minimum: round up, then one more cycle.
  localparam int RST_CYC = (`HCI_RESET_NS + `HCI_CLK_NS - 1) / `HCI_CLK_NS + 1;

  hci_host_state_t state;
  logic [16:0] cnt;
  logic [4:0] nbit;
  logic [19:0] frame;
  logic wr, ser, intel, sclk;
  logic [8:0] sync_q;
  wire [7:0] s_data = sync_q[8:1];
  wire s_int_n = sync_q[0];
  wire [16:0] hold = 17'(`HCI_SCK_HALF - 1);

  hci_sync2 #(.WIDTH(9)) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in({bus.data_bus, bus.int_n}),
    .sync_out(sync_q)
  );

  assign cmd_ready_out = (state == HCI_S_IDLE);
  // The synchroniser wakes up holding zeros, which would read as a pending interrupt until it has filled.
  assign irq_out = !s_int_n && (state != HCI_S_RST);
  // Serial mode takes the clock from sclk and the data from the top bit of the frame shift register.
  assign bus.strobe_n = ser ? sclk : frame[1];
  assign bus.rw_sdi = ser ? frame[19] : frame[0];

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= HCI_S_RST;
      cnt <= 17'h00000;
      nbit <= 5'h00;
      frame <= 20'h00003;
      wr <= 1'b0;
      ser <= 1'b0;
      intel <= 1'b0;
      sclk <= 1'b0;
      bus.dev_reset_n <= 1'b0;
      bus.cs_n <= 1'b1;
      bus.addr <= '0;
      bus.bus_style_select <= 1'b0;
      bus.serial_host_select <= 1'b0;
      bus.host_data <= 8'h00;
      bus.host_data_oe <= 8'h00;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 8'h00;
    end else begin
      rsp_valid_out <= 1'b0;
      cnt <= cnt + 17'h00001;
      case (state)
        HCI_S_RST: begin
          if (cnt == 17'(RST_CYC - 1)) begin
            bus.dev_reset_n <= 1'b1;
            cnt <= 17'h00000;
            state <= HCI_S_WAIT;
          end
        end
        HCI_S_WAIT: begin
          if (cnt == 17'(READY_CYC - 1)) begin
            state <= HCI_S_IDLE;
          end
        end
        HCI_S_IDLE: begin
          if (cmd_valid_in) begin
            wr <= cmd_write_in;
            ser <= serial_mode_in;
            intel <= intel_mode_in;
            bus.serial_host_select <= serial_mode_in;
            bus.bus_style_select <= intel_mode_in;
            bus.addr <= serial_mode_in ? '0 : cmd_addr_in;
            bus.host_data <= cmd_wdata_in;
            bus.host_data_oe <= (cmd_write_in && !serial_mode_in) ? 8'hFF : 8'h00;
            frame <= serial_mode_in ? {!cmd_write_in, cmd_addr_in, cmd_wdata_in} :
              {18'h00000, 1'b1, intel_mode_in || !cmd_write_in};
            bus.cs_n <= 1'b0;
            sclk <= 1'b0;
            nbit <= 5'h00;
            cnt <= 17'h00000;
            state <= HCI_S_SETUP;
          end
        end
        HCI_S_SETUP: begin
          if (cnt == 17'(`HCI_SETUP_CYC - 1)) begin
            cnt <= 17'h00000;
            if (ser) begin
              state <= HCI_S_SER;
            end else begin
              frame[1] <= intel && wr;
              frame[0] <= intel ? !wr : frame[0];
              state <= HCI_S_STROBE;
            end
          end
        end
        HCI_S_STROBE: begin
          if (cnt == 17'(`HCI_STROBE_CYC - 1)) begin
            rsp_rdata_out <= s_data;
            frame[1:0] <= {1'b1, intel ? 1'b1 : frame[0]};
            cnt <= 17'h00000;
            state <= HCI_S_RELEASE;
          end
        end
        // output on fall, sample on rise
        HCI_S_SER: begin
          if (cnt == hold) begin
            cnt <= 17'h00000;
            sclk <= !sclk;
            if (!sclk) begin
              nbit <= nbit + 5'h01;
              if (nbit >= 5'(`HCI_SER_HDR_BITS)) begin
                rsp_rdata_out <= {rsp_rdata_out[6:0], s_data[0]};
              end
            end else if (nbit == 5'(`HCI_SER_BITS)) begin
              sclk <= 1'b0;
              state <= HCI_S_RELEASE;
            end else begin
              frame <= {frame[18:0], 1'b0};
            end
          end
        end
        HCI_S_RELEASE: begin
          if (cnt == 17'(`HCI_RELEASE_CYC - 1)) begin
            bus.cs_n <= 1'b1;
            bus.host_data_oe <= 8'h00;
            cnt <= 17'h00000;
            state <= HCI_S_GAP;
          end
        end
        HCI_S_GAP: begin
          if (cnt == 17'(`HCI_GAP_CYC - 1)) begin
            rsp_valid_out <= 1'b1;
            ser <= 1'b0;
            frame <= 20'h00003;
            state <= HCI_S_IDLE;
          end
        end
        default: begin
          state <= HCI_S_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== hw/hci_defines.svh ====
/*
  Offsets, field positions, reset values and timing figures of the host control interface.
  Assumes inclusion by bare name from the package and the host and device modules.
*/
`ifndef HCI_DEFINES_SVH
`define HCI_DEFINES_SVH

`define HCI_ADDR_W 11
`define HCI_REG_GPIO 11'h006
`define HCI_REG_REFSEL 11'h007
`define HCI_GPIO_DIR_LSB 0
`define HCI_GPIO_LVL_LSB 2
`define HCI_REFA_LSB 0
`define HCI_REFB_LSB 3
`define HCI_GPIO_RESET 8'h00
`define HCI_REFSEL_RESET 8'h00
`define HCI_CLK_NS 20
`define HCI_RESET_NS 100
`define HCI_READY_MS 2
`define HCI_SER_HDR_BITS 12
`define HCI_SER_BITS 20
`define HCI_SETUP_CYC 4
`define HCI_STROBE_CYC 10
`define HCI_RELEASE_CYC 4
`define HCI_GAP_CYC 4
`define HCI_SCK_HALF 8

`endif

// ==== hw/hci_pkg.sv ====
/*
  Types of the host control interface: the address type and the state encoding of the host end.
  Assumes the defines header is on the include path.
*/
package hci_pkg;
  `include "hci_defines.svh"

  typedef logic [`HCI_ADDR_W-1:0] hci_addr_t;

  typedef enum logic [7:0] {
    HCI_S_RST = 8'h01,
    HCI_S_WAIT = 8'h02,
    HCI_S_IDLE = 8'h04,
    HCI_S_SETUP = 8'h08,
    HCI_S_STROBE = 8'h10,
    HCI_S_RELEASE = 8'h20,
    HCI_S_GAP = 8'h40,
    HCI_S_SER = 8'h80
  } hci_host_state_t;
endpackage

// ==== hw/hci_bus_if.sv ====
/*
  Pins between the microprocessor host and the transceiver control port.
  Assumes the bench joins one host and one device; shared wires are resolved here from the enables.
*/
`timescale 1ns/1ps
interface hci_bus_if;
  import hci_pkg::*;
  logic dev_reset_n;
  logic cs_n;
  hci_addr_t addr;
  logic strobe_n;
  logic rw_sdi;
  logic bus_style_select;
  logic serial_host_select;
  logic [7:0] host_data;
  logic [7:0] host_data_oe;
  logic [7:0] dev_data;
  logic [7:0] dev_data_oe;
  logic [7:0] data_bus;
  logic int_oe;
  logic int_n;

  // Undriven data lines float high through the pull-ups.
  genvar i;
  for (i = 0; i < 8; i++) begin : g_bus
    assign data_bus[i] = dev_data_oe[i] ? dev_data[i] : (host_data_oe[i] ? host_data[i] : 1'b1);
  end
  // Open drain: only pulled low.
  assign int_n = int_oe ? 1'b0 : 1'b1;

  modport host (output dev_reset_n, cs_n, addr, strobe_n, rw_sdi, bus_style_select, serial_host_select,
    host_data, host_data_oe, input data_bus, int_n);
  modport device (input cs_n, addr, strobe_n, rw_sdi, bus_style_select, serial_host_select, data_bus,
    output dev_data, dev_data_oe, int_oe);
endinterface

// ==== hw/hci_sync2.sv ====
/*
  Two flip-flop synchroniser for a vector of pin levels.
  Assumes each bit is an independent level; multi-bit buses must be stable while sampled.
*/
`timescale 1ns/1ps
module hci_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ==== hw/hci_device.sv ====
/*
  Device end of the transceiver control port: parallel (two strobe styles) and serial register
  access, general-purpose pins, reference clock selection, transmit float and interrupt pin.
  Assumes every pin is asynchronous to clk_sys_in; reset_n_in is the device reset pin.
*/
// Summary of operation
// - Reference A follows link chosen by bits 2:0.
// - Reference B follows link chosen by bits 5:3.
// - Reset low beyond 100 ns resets everything.
// - Host waits 2 ms after reset.
// - Direction bits set each general pin's direction.
// - Input pins report level in level bits.
// - Output pins drive written level bits.
// - Float input high floats all transmit pairs.
// - Open-drain interrupt low while unmasked events pending.
// - Respond only while chip select low.
// - Chip select high once clears test mode.
// - Each access opens with new select fall.
// - Parallel decodes address; serial grounds address.
// - Parallel data on bus; serial uses bit 0.
// - Style pin picks Motorola or Intel strobes.
// - Motorola direction high reads, low writes.
// - Intel shared pin is write strobe.
// - Serial frames shift in on data input.
// - Select pin low parallel, high serial.
// - Serial output on fall, input on rise.
// - Shared strobe is data or read strobe.
`timescale 1ns/1ps
`include "hci_defines.svh"
module hci_device
  import hci_pkg::*;
#(
  parameter int LINKS = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Host pins
  hci_bus_if.device bus,
  // Recovered clocks and reference outputs
  input wire logic [LINKS-1:0] rx_clock_in,
  output logic recovered_clock_out_a_out,
  output logic recovered_clock_out_b_out,
  // General-purpose pins
  input wire logic [1:0] gpio_pin_in,
  output logic [1:0] gpio_pin_out,
  output logic [1:0] gpio_pin_oe_out,
  // Line side
  input wire logic transmit_float_input_in,
  output logic [LINKS-1:0] line_transmit_pair_oe_out,
  // Interrupt sources, already masked
  input wire logic interrupt_active_in
);
  localparam int SYNC_W = 5 + `HCI_ADDR_W + 8 + 1 + 2 + LINKS;

  logic [SYNC_W-1:0] sync_q;
  logic s_cs_n, s_stb_n, s_rw, s_mpm, s_spi, s_thz;
  hci_addr_t s_addr;
  logic [7:0] s_data;
  logic [1:0] s_gpio;
  logic [LINKS-1:0] s_rx;

  logic test_mode, acc_done, stb_q, sdo, ser_read;
  logic [4:0] bit_cnt;
  logic [10:0] rx_sh;
  hci_addr_t ser_addr;
  logic [7:0] tx_sh, gpio_reg, refsel_reg, data_q, data_oe_q;
  logic [1:0] level_rd;

  hci_sync2 #(.WIDTH(SYNC_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in({bus.cs_n, bus.strobe_n, bus.rw_sdi, bus.bus_style_select, bus.serial_host_select,
      bus.addr, bus.data_bus, transmit_float_input_in, gpio_pin_in, rx_clock_in}),
    .sync_out(sync_q)
  );
  assign {s_cs_n, s_stb_n, s_rw, s_mpm, s_spi, s_addr, s_data, s_thz, s_gpio, s_rx} = sync_q;

  wire par_sel = !s_spi && !test_mode && !s_cs_n;
  wire ser_sel = s_spi && !test_mode && !s_cs_n;

  wire rd_qual = s_mpm ? !s_stb_n : (!s_stb_n && s_rw);
  wire wr_qual = s_mpm ? !s_rw : (!s_stb_n && !s_rw);
  wire par_rd = par_sel && rd_qual;
  wire par_wr = par_sel && wr_qual && !acc_done;

  wire sclk_rise = ser_sel && s_stb_n && !stb_q;
  wire sclk_fall = ser_sel && !s_stb_n && stb_q;
  wire hdr_done = sclk_rise && (bit_cnt == 5'(`HCI_SER_HDR_BITS - 1));
  wire ser_wr = sclk_rise && !ser_read && (bit_cnt == 5'(`HCI_SER_BITS - 1));
  wire ser_out_phase = bit_cnt >= 5'(`HCI_SER_HDR_BITS);

  wire wr_en = par_wr || ser_wr;
  wire [`HCI_ADDR_W-1:0] wr_addr = s_spi ? ser_addr : s_addr;
  wire [7:0] wr_data = s_spi ? {rx_sh[6:0], s_rw} : s_data;
  wire [`HCI_ADDR_W-1:0] hdr_addr = {rx_sh[9:0], s_rw};

  wire [1:0] gpio_dir = gpio_reg[`HCI_GPIO_DIR_LSB +: 2];
  wire [1:0] gpio_lvl = gpio_reg[`HCI_GPIO_LVL_LSB +: 2];

  genvar g;
  for (g = 0; g < 2; g++) begin : g_level
    assign level_rd[g] = gpio_dir[g] ? gpio_lvl[g] : s_gpio[g];
  end

  // Unmapped addresses read as zero, as do the upper four bits of the pin register.
  function automatic logic [7:0] reg_read(input hci_addr_t a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `HCI_REG_GPIO) begin
      v = {4'h0, level_rd, gpio_dir};
    end else if (a == `HCI_REG_REFSEL) begin
      v = refsel_reg;
    end
    return v;
  endfunction

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      test_mode <= 1'b1;
      acc_done <= 1'b0;
      stb_q <= 1'b1;
    end else begin
      if (s_cs_n) begin
        test_mode <= 1'b0;
      end
      acc_done <= !s_cs_n && (acc_done || par_wr);
      stb_q <= s_stb_n;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_cnt <= 5'h00;
      rx_sh <= 11'h000;
      ser_addr <= '0;
      ser_read <= 1'b0;
    end else if (s_cs_n) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise && bit_cnt < 5'(`HCI_SER_BITS)) begin
      bit_cnt <= bit_cnt + 5'h01;
      rx_sh <= {rx_sh[9:0], s_rw};
      if (hdr_done) begin
        ser_read <= rx_sh[10];
        ser_addr <= hdr_addr;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_sh <= 8'h00;
      sdo <= 1'b0;
    end else if (hdr_done) begin
      tx_sh <= reg_read(hdr_addr);
    end else if (sclk_fall && ser_out_phase) begin
      sdo <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gpio_reg <= `HCI_GPIO_RESET;
      refsel_reg <= `HCI_REFSEL_RESET;
    end else if (wr_en) begin
      if (wr_addr == `HCI_REG_GPIO) begin
        gpio_reg <= {4'h0, wr_data[3:0]};
      end
      if (wr_addr == `HCI_REG_REFSEL) begin
        refsel_reg <= wr_data;
      end
    end
  end

  // parallel bus or serial bit 0
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_q <= 8'h00;
      data_oe_q <= 8'h00;
    end else begin
      data_q <= s_spi ? {7'h00, sdo} : reg_read(s_addr);
      data_oe_q <= par_rd ? 8'hFF : ((ser_sel && ser_read && ser_out_phase) ? 8'h01 : 8'h00);
    end
  end
  assign bus.dev_data = data_q;
  assign bus.dev_data_oe = data_oe_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      recovered_clock_out_a_out <= 1'b0;
      recovered_clock_out_b_out <= 1'b0;
      line_transmit_pair_oe_out <= '0;
      bus.int_oe <= 1'b0;
    end else begin
      recovered_clock_out_a_out <= s_rx[refsel_reg[`HCI_REFA_LSB +: 3]];
      recovered_clock_out_b_out <= s_rx[refsel_reg[`HCI_REFB_LSB +: 3]];
      line_transmit_pair_oe_out <= {LINKS{!s_thz}};
      bus.int_oe <= interrupt_active_in;
    end
  end

  assign gpio_pin_oe_out = gpio_dir;
  assign gpio_pin_out = gpio_lvl;
endmodule

// ==== tb/hci_checker.sv ====
/*
  Concurrent checks on the pins between the host end and the device end.
  Assumes it sits beside the interface in the bench, on the one system clock.
*/
`timescale 1ns/1ps
module hci_checker
  import hci_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Host driven pins
  input wire logic dev_reset_n,
  input wire logic cs_n,
  input wire hci_addr_t addr,
  input wire logic strobe_n,
  input wire logic rw_sdi,
  input wire logic bus_style_select,
  input wire logic serial_host_select,
  input wire logic [7:0] host_data_oe,
  // Device driven pins
  input wire logic [7:0] dev_data,
  input wire logic [7:0] dev_data_oe
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  wire par_mode = !serial_host_select;
  wire read_qual = !cs_n && !strobe_n && (bus_style_select || rw_sdi);

  // The device lags its pins by the synchroniser, so drive is tied to the qualifier three or four cycles back.
  a_read_drive_only: assert property (par_mode && (|dev_data_oe) |-> $past(read_qual, 3) || $past(read_qual, 4))
    else $error("device drives data bus outside a read");
  a_no_bus_fight: assert property (!((|dev_data_oe) && (|host_data_oe)))
    else $error("host and device drive data bus together");
  a_serial_bit_zero: assert property (serial_host_select |-> dev_data_oe[7:1] == 7'h00)
    else $error("device drives upper data bits in serial mode");
  a_serial_addr_ground: assert property (serial_host_select && !cs_n |-> addr == 11'h000)
    else $error("address not grounded in serial mode");
  a_setup_before_strobe: assert property (par_mode && $stable(bus_style_select)
    && ($fell(strobe_n) || (bus_style_select && $fell(rw_sdi))) |-> !cs_n && $past(!cs_n, 3) && $stable(addr))
    else $error("strobe without settled select and address");
  a_strobe_in_select: assert property (par_mode && (!strobe_n || (bus_style_select && !rw_sdi)) |-> !cs_n)
    else $error("strobe active while chip select high");
  a_sdo_on_fall: assert property (serial_host_select && dev_data_oe[0] && $past(dev_data_oe[0])
    && $changed(dev_data[0]) |-> !strobe_n)
    else $error("serial output changed while serial clock high");
  a_reset_long: assert property ($rose(dev_reset_n) |-> !$past(dev_reset_n, 5) && !$past(dev_reset_n, 3))
    else $error("device reset pulse too short");
endmodule

// ==== tb/host_control_interface_test.sv ====
/*
  Self-checking bench: host end and device end joined by the pin interface, with the checker beside it.
  Assumes a 50 MHz clock and the shortened ready wait of twenty cycles.
*/
`timescale 1ns/1ps
module host_control_interface_test;
  import hci_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in;
  logic serial_mode, intel_mode, cmd_valid, cmd_write, cmd_ready, rsp_valid, irq, ref_a, ref_b, tx_float, int_act;
  logic [10:0] cmd_addr;
  logic [7:0] cmd_wdata, rsp_rdata, rx_clock, line_oe, rd;
  logic [1:0] gpio_in, gpio_out, gpio_oe;
  int fails = 0;
  int num_checks = 0;

  hci_bus_if bus ();
  always #10 clk_sys_in = ~clk_sys_in;

  hci_host #(.READY_CYC(20)) hci_host_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .bus(bus),
    .serial_mode_in(serial_mode), .intel_mode_in(intel_mode), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rsp_rdata), .irq_out(irq));
  hci_device hci_device_inst (.clk_sys_in(clk_sys_in), .reset_n_in(bus.dev_reset_n), .bus(bus),
    .rx_clock_in(rx_clock), .recovered_clock_out_a_out(ref_a), .recovered_clock_out_b_out(ref_b),
    .gpio_pin_in(gpio_in), .gpio_pin_out(gpio_out), .gpio_pin_oe_out(gpio_oe),
    .transmit_float_input_in(tx_float), .line_transmit_pair_oe_out(line_oe), .interrupt_active_in(int_act));
  hci_checker hci_checker_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .dev_reset_n(bus.dev_reset_n),
    .cs_n(bus.cs_n), .addr(bus.addr), .strobe_n(bus.strobe_n), .rw_sdi(bus.rw_sdi),
    .bus_style_select(bus.bus_style_select), .serial_host_select(bus.serial_host_select),
    .host_data_oe(bus.host_data_oe), .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One register access through the host end; the answer lands in rd.
  task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, wr, a, d};
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    if (n == 1000) begin
      fails++;
      $display("FAIL %0t no answer from access", $time);
    end
    rd = rsp_rdata;
  endtask

  task automatic t_reset;
    reset_n_in = 1'b0;
    tick(12);
    reset_n_in = 1'b1;
    check_byte({7'h00, cmd_ready}, 8'h00);
    check_byte({7'h00, irq}, 8'h00);
    gpio_in = 2'b10;
    access(1'b0, 11'h007, 8'h00);
    check_byte(rd, 8'h00);
    access(1'b0, 11'h006, 8'h00);
    check_byte(rd, 8'h08);
  endtask

  // Every link on both outputs, in each of the three access styles.
  task automatic t_refsel;
    logic [2:0] a;
    for (int m = 0; m < 3; m++) begin
      serial_mode = (m == 2);
      intel_mode = (m == 1);
      for (int i = 0; i < 8; i++) begin
        a = i[2:0];
        access(1'b1, 11'h007, {2'b00, ~a, a});
        rx_clock = 8'h01 << i;
        tick(6);
        check_byte({6'h00, ref_b, ref_a}, 8'h01);
        rx_clock = 8'h80 >> i;
        tick(6);
        check_byte({6'h00, ref_b, ref_a}, 8'h02);
        access(1'b0, 11'h007, 8'h00);
        check_byte(rd, {2'b00, ~a, a});
      end
    end
    serial_mode = 1'b0;
    intel_mode = 1'b0;
  endtask

  task automatic t_gpio;
    access(1'b1, 11'h006, 8'h0D);
    tick(4);
    check_byte({4'h0, gpio_oe, gpio_out}, 8'h07);
    gpio_in = 2'b01;
    access(1'b0, 11'h006, 8'h00);
    check_byte(rd, 8'h05);
    gpio_in = 2'b10;
    access(1'b0, 11'h006, 8'h00);
    check_byte(rd, 8'h0D);
    access(1'b1, 11'h006, 8'h02);
    gpio_in = 2'b11;
    access(1'b0, 11'h006, 8'h00);
    check_byte(rd, 8'h06);
  endtask

  // Unmapped place, then reserved bits of the pin register.
  task automatic t_unmapped;
    access(1'b1, 11'h7FF, 8'h3C);
    access(1'b0, 11'h7FF, 8'h00);
    check_byte(rd, 8'h00);
    access(1'b0, 11'h007, 8'h00);
    check_byte(rd, 8'h07);
    access(1'b1, 11'h006, 8'hFF);
    access(1'b0, 11'h006, 8'h00);
    check_byte(rd, 8'h0F);
  endtask

  task automatic t_pins;
    tx_float = 1'b1;
    tick(5);
    check_byte(line_oe, 8'h00);
    tx_float = 1'b0;
    tick(5);
    check_byte(line_oe, 8'hFF);
    int_act = 1'b1;
    tick(10);
    check_byte({6'h00, bus.int_n, irq}, 8'h01);
    int_act = 1'b0;
    tick(10);
    check_byte({6'h00, bus.int_n, irq}, 8'h02);
  endtask

  task automatic complete_run;
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    reset_n_in = 1'b0;
    {serial_mode, intel_mode, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
    {rx_clock, tx_float, int_act, gpio_in} = '0;
    t_reset();
    t_refsel();
    t_gpio();
    t_unmapped();
    t_pins();
    complete_run();
  end

  // The whole run needs well under ten thousand cycles.
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    fails++;
    $display("FAIL %0t watchdog expired", $time);
    complete_run();
  end
endmodule
